// [rtl/smc_port.sv]
// Register port of the controller message channel: APB slave, byte FIFOs.
// Assumes APB signals and far-side strobes are synchronous to clock_i.
// Operation
// R1 - Status bit 7 shows receive head byte carries the command marker.
// R2 - Status bit 6 sets on marker byte during outbound system bus transfer.
// R3 - Status bit 5 sets on far-side purge indication, write one clears.
// R4 - Status bit 4 sets on system bus transfer completion, write one clears.
// R5 - Status bit 3 latches when receive FIFO read while empty.
// R6 - Status bit 2 latches when transmit FIFO written while full.
// R7 - Status bit 1 shows receive FIFO holds one unit of current width.
// R8 - Status bit 0 shows transmit room for one unit, high after reset.
// R9 - Eight mask bits gate matching status bits onto the interrupt output.
// R10 - Byte transmit write into full FIFO sets transmit overflow.
// R11 - Word transmit write with under four free entries sets overflow.
// R12 - Word read with under four queued bytes sets receive underflow.
// R13 - Plain payload writes queue bytes with marker bit cleared.
// R14 - Byte data access forces the matching width setting to one byte.
// R15 - Word data access forces the matching width setting to four bytes.
// R16 - Word transfers move least significant byte first, then ascending.
// R17 - Byte opener write queues its byte with the marker set.
// R18 - Word opener write marks only the first, least significant byte.
// R19 - Software enables the channel before pushing and keeps it enabled.
// R20 - Channel starts in loopback; clearing the bit selects normal operation.
// R21 - Flush bit empties FIFOs over cycles, self clears; busy bit reads.
// R22 - Writing zero to sticky bits or writing read-only bits changes nothing.
// R23 - Underflow reads do not pop; overflow writes are discarded.
`timescale 1ns/1ns

module smc_fifo #(
	parameter int W = 9,
	parameter int D = 4
) (
	input  wire logic                 clock_i,
	input  wire logic                 reset_i,
	input  wire logic                 flush_i,
	input  wire logic                 in_valid_i,
	output logic                      in_ready_o,
	input  wire logic [W-1:0]         in_data_i,
	output logic                      out_valid_o,
	input  wire logic                 out_ready_i,
	output logic [W-1:0]              out_data_o,
	output logic [$clog2(D):0]        count_o
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} smc_fifo_st_t;

	smc_fifo_st_t f;
	smc_fifo_st_t n;
	logic         push;
	logic         pop;

	assign in_ready_o  = (f.cnt != CNT_FULL);
	assign out_valid_o = (f.cnt != '0);
	assign out_data_o  = f.mem[f.rp];
	assign count_o     = f.cnt;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_ready_i & out_valid_o;

	always_comb begin
		n = f;
		if (push) begin
			n.mem[f.wp] = in_data_i;
			n.wp = f.wp + 1'b1;
		end
		if (pop) begin
			n.rp = f.rp + 1'b1;
		end
		n.cnt = f.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		if (flush_i) begin
			n.wp = '0;
			n.rp = '0;
			n.cnt = '0;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			f <= '0;
		end else begin
			f <= n;
		end
	end
endmodule

module smc_port (
	input  wire logic                        clock_i,
	input  wire logic                        reset_i,
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [smc_pkg::ADDR_W-1:0]  paddr_i,
	input  wire logic [31:0]                 pwdata_i,
	output logic [31:0]                      prdata_o,
	output logic                             pready_o,
	output logic [7:0]                       tx_byte_o,
	output logic                             tx_marker_o,
	output logic                             tx_valid_o,
	input  wire logic                        tx_ready_i,
	input  wire logic [7:0]                  rx_byte_i,
	input  wire logic                        rx_marker_i,
	input  wire logic                        rx_valid_i,
	output logic                             rx_ready_o,
	input  wire logic                        sysbus_busy_i,
	input  wire logic                        sysbus_transfer_complete_i,
	input  wire logic                        remote_purge_i,
	output logic                             purge_in_progress_o,
	output logic                             channel_irq_o
);
	import smc_pkg::*;

	typedef struct packed {
		smc_state_t  st;
		logic        loopback;
		logic        enable;
		logic        rx_w;
		logic        tx_w;
		logic        flush;
		logic [2:0]  flush_cnt;
		logic [4:0]  sticky;
		logic [7:0]  mask;
		logic [31:0] shift;
		logic [2:0]  left;
		logic        is_word;
		logic        is_read;
		logic        opener_first;
		logic [31:0] prdata;
		logic        irq;
	} smc_core_t;

	smc_core_t                   s;
	smc_core_t                   n;
	logic                        acc;
	logic                        is_data;
	logic                        is_word;
	logic                        is_opener;
	logic [2:0]                  need;
	logic [2:0]                  tx_cnt;
	logic [2:0]                  rx_cnt;
	logic [2:0]                  tx_free;
	logic                        tx_enough;
	logic                        rx_enough;
	logic                        tx_room;
	logic                        rx_unit;
	logic                        rx_cmd;
	logic [7:0]                  status_val;
	logic                        tx_in_valid;
	logic                        tx_in_ready;
	logic [FIFO_WIDTH-1:0]       tx_in_data;
	logic                        tx_push;
	logic                        tx_out_valid;
	logic                        tx_out_ready;
	logic [FIFO_WIDTH-1:0]       tx_out_data;
	logic                        tx_pop;
	logic                        rx_in_valid;
	logic                        rx_in_ready;
	logic [FIFO_WIDTH-1:0]       rx_in_data;
	logic                        rx_out_valid;
	logic [FIFO_WIDTH-1:0]       rx_out_data;
	logic                        rx_take;
	logic                        sierr_ev;
	logic                        over_ev;
	logic                        under_ev;
	logic [4:0]                  clr;

	assign acc       = psel_i & penable_i & (s.st == SMC_IDLE);
	assign is_word   = (paddr_i == OFS_WORD_PAYLOAD) | (paddr_i == OFS_WORD_OPENER);
	assign is_opener = (paddr_i == OFS_BYTE_OPENER) | (paddr_i == OFS_WORD_OPENER);
	assign is_data   = is_word | is_opener | (paddr_i == OFS_BYTE_PAYLOAD);
	assign need      = is_word ? WORD_BYTES : 3'h1;
	assign tx_free   = 3'(FIFO_DEPTH) - tx_cnt;
	assign tx_enough = tx_free >= need; // see R10, R11
	assign rx_enough = rx_cnt >= need; // see R12
	assign tx_room   = tx_free >= (s.tx_w ? WORD_BYTES : 3'h1); // see R8
	assign rx_unit   = rx_cnt >= (s.rx_w ? WORD_BYTES : 3'h1); // see R7
	assign rx_cmd    = rx_out_valid & rx_out_data[MARKER_BIT]; // see R1
	assign status_val = {rx_cmd, s.sticky, rx_unit, tx_room};

	// Only the bus sequencer fills transmit and drains receive
	assign tx_in_valid = (s.st == SMC_MOVE) & ~s.is_read;
	assign tx_in_data  = {s.opener_first, s.shift[7:0]}; // see R13, R17, R18
	assign tx_push     = tx_in_valid & tx_in_ready;
	assign rx_take     = (s.st == SMC_MOVE) & s.is_read;

	// Loopback turns transmit bytes straight back into receive
	assign tx_out_ready = s.enable & (s.loopback ? rx_in_ready : tx_ready_i); // see R20
	assign tx_pop       = tx_out_valid & tx_out_ready;
	assign tx_valid_o   = s.enable & ~s.loopback & tx_out_valid;
	assign tx_byte_o    = tx_out_data[7:0];
	assign tx_marker_o  = tx_out_data[MARKER_BIT];
	assign rx_in_valid  = s.loopback ? tx_pop : rx_valid_i;
	assign rx_in_data   = s.loopback ? tx_out_data : {rx_marker_i, rx_byte_i};
	assign rx_ready_o   = ~s.loopback & rx_in_ready;

	assign sierr_ev = tx_pop & tx_out_data[MARKER_BIT] & sysbus_busy_i & ~s.loopback; // see R2

	assign prdata_o            = s.prdata;
	assign pready_o            = (s.st == SMC_DONE);
	assign purge_in_progress_o = s.flush;
	assign channel_irq_o       = s.irq;

	smc_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_tx (
		.clock_i     (clock_i),
		.reset_i     (reset_i),
		.flush_i     (s.flush),
		.in_valid_i  (tx_in_valid),
		.in_ready_o  (tx_in_ready),
		.in_data_i   (tx_in_data),
		.out_valid_o (tx_out_valid),
		.out_ready_i (tx_out_ready),
		.out_data_o  (tx_out_data),
		.count_o     (tx_cnt)
	);

	smc_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_rx (
		.clock_i     (clock_i),
		.reset_i     (reset_i),
		.flush_i     (s.flush),
		.in_valid_i  (rx_in_valid),
		.in_ready_o  (rx_in_ready),
		.in_data_i   (rx_in_data),
		.out_valid_o (rx_out_valid),
		.out_ready_i (rx_take),
		.out_data_o  (rx_out_data),
		.count_o     (rx_cnt)
	);

	always_comb begin
		n = s;
		over_ev = 1'b0;
		under_ev = 1'b0;
		clr = 5'h00;
		case (s.st)
			SMC_IDLE: begin
				if (acc) begin
					n.st = SMC_DONE;
					n.prdata = 32'h0000_0000;
					if (is_data) begin
						if (pwrite_i) begin
							n.tx_w = is_word; // see R14, R15
						end else begin
							n.rx_w = is_word; // see R14, R15
						end
						// Refused accesses neither push nor pop
						if (pwrite_i ? tx_enough : rx_enough) begin // see R23
							n.st = SMC_MOVE;
							n.left = need;
							n.is_word = is_word;
							n.is_read = ~pwrite_i;
							n.shift = pwdata_i;
							n.opener_first = is_opener;
						end
						over_ev = pwrite_i & ~tx_enough; // see R6, R10, R11
						under_ev = ~pwrite_i & ~rx_enough; // see R5, R12
					end else if (pwrite_i) begin
						case (paddr_i)
							OFS_CONTROL: begin
								n.loopback = pwdata_i[CTL_LOOPBACK]; // see R20
								n.enable = pwdata_i[CTL_ENABLE];
								n.rx_w = pwdata_i[CTL_RX_WIDTH];
								n.tx_w = pwdata_i[CTL_TX_WIDTH];
								if (pwdata_i[CTL_PURGE_REQ]) begin // see R21
									n.flush = 1'b1;
									n.flush_cnt = FLUSH_CYCLES - 3'h1;
								end
							end
							OFS_STATUS: clr = pwdata_i[ST_STICKY_HI:ST_STICKY_LO]; // see R22
							OFS_INT_MASK: n.mask = pwdata_i[7:0];
							default: ;
						endcase
					end else begin
						case (paddr_i)
							OFS_CONTROL: n.prdata = {26'h0, s.loopback, s.enable, s.rx_w,
								s.tx_w, s.flush, s.flush};
							OFS_STATUS: n.prdata = {24'h0, status_val};
							OFS_INT_MASK: n.prdata = {24'h0, s.mask};
							default: ;
						endcase
					end
				end
			end
			SMC_MOVE: begin
				n.left = s.left - 3'h1;
				if (s.is_read) begin
					// Earlier bytes slide down, so the first byte lands lowest
					n.shift = {rx_out_data[7:0], s.shift[31:8]}; // see R16
					if (s.left == 3'h1) begin
						n.prdata = s.is_word ? n.shift : {24'h0, rx_out_data[7:0]};
					end
				end else begin
					n.shift = {8'h00, s.shift[31:8]}; // see R16
					n.opener_first = 1'b0; // see R18
				end
				if (s.left == 3'h1) begin
					n.st = SMC_DONE;
				end
			end
			SMC_DONE: n.st = SMC_IDLE;
			default: n.st = SMC_IDLE;
		endcase
		// Hardware set wins over a same-cycle software clear
		n.sticky = (s.sticky & ~clr) | {sierr_ev, remote_purge_i,
			sysbus_transfer_complete_i, under_ev, over_ev}; // see R2, R3, R4, R5, R6, R22
		if (s.flush) begin
			if (s.flush_cnt == 3'h0) begin
				n.flush = 1'b0; // see R21
			end else begin
				n.flush_cnt = s.flush_cnt - 3'h1;
			end
		end
		n.irq = |(status_val & s.mask); // see R9
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			s.st <= SMC_IDLE;
			s.loopback <= RST_LOOPBACK;
			s.enable <= RST_ENABLE;
			s.rx_w <= 1'b0;
			s.tx_w <= 1'b0;
			s.flush <= 1'b0;
			s.flush_cnt <= 3'h0;
			s.sticky <= 5'h00;
			s.mask <= RST_MASK;
			s.shift <= 32'h0000_0000;
			s.left <= 3'h0;
			s.is_word <= 1'b0;
			s.is_read <= 1'b0;
			s.opener_first <= 1'b0;
			s.prdata <= 32'h0000_0000;
			s.irq <= 1'b0;
		end else begin
			s <= n;
		end
	end

	localparam int FL_LIM = 6;

	sequence s_flush_req;
		acc && pwrite_i && (paddr_i == OFS_CONTROL) && pwdata_i[CTL_PURGE_REQ];
	endsequence
	sequence s_word_push_ok;
		acc && pwrite_i && is_word && tx_enough;
	endsequence

	// Follows the head marker through the status read path, not just the flag wire
	property p_head_cmd;
		@(posedge clock_i) disable iff (reset_i)
		(acc && !pwrite_i && paddr_i == OFS_STATUS) |=>
		s.prdata[ST_CMD_HEAD] == ($past(rx_out_valid) && $past(rx_out_data[MARKER_BIT]));
	endproperty
	a_head_cmd: assert property (p_head_cmd) else $error("cmd flag mismatch"); // see R1

	property p_sierr;
		@(posedge clock_i) disable iff (reset_i)
		(tx_pop && tx_out_data[MARKER_BIT] && sysbus_busy_i && !s.loopback) |=> s.sticky[4];
	endproperty
	a_sierr: assert property (p_sierr) else $error("marker error not set"); // see R2

	property p_purge;
		@(posedge clock_i) disable iff (reset_i)
		remote_purge_i |=> s.sticky[3];
	endproperty
	a_purge: assert property (p_purge) else $error("purge flag not set"); // see R3

	property p_xdone;
		@(posedge clock_i) disable iff (reset_i)
		sysbus_transfer_complete_i |=> s.sticky[2];
	endproperty
	a_xdone: assert property (p_xdone) else $error("done flag not set"); // see R4

	property p_under;
		@(posedge clock_i) disable iff (reset_i)
		(acc && is_data && !pwrite_i && !rx_enough) |=> s.sticky[1] && s.st == SMC_DONE;
	endproperty
	a_under: assert property (p_under) else $error("underflow missed"); // see R5, R12, R23

	property p_over;
		@(posedge clock_i) disable iff (reset_i)
		(acc && is_data && pwrite_i && !tx_enough) |=> s.sticky[0] && !tx_push;
	endproperty
	a_over: assert property (p_over) else $error("overflow missed"); // see R6, R10, R11, R23

	property p_levels;
		@(posedge clock_i) disable iff (reset_i)
		status_val[ST_RX_UNIT] == (rx_cnt >= (s.rx_w ? 3'h4 : 3'h1)) &&
		status_val[ST_TX_ROOM] == (tx_cnt <= (s.tx_w ? 3'h0 : 3'h3));
	endproperty
	a_levels: assert property (p_levels) else $error("level flag wrong"); // see R7, R8

	property p_irq;
		@(posedge clock_i) disable iff (reset_i)
		##1 channel_irq_o == |($past(status_val) & $past(s.mask));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch"); // see R9

	property p_width;
		@(posedge clock_i) disable iff (reset_i)
		(acc && is_data) |=> (($past(pwrite_i) ? s.tx_w : s.rx_w) == $past(is_word));
	endproperty
	a_width: assert property (p_width) else $error("width not forced"); // see R14, R15

	property p_word_order;
		@(posedge clock_i) disable iff (reset_i)
		s_word_push_ok |=>
		(tx_push && tx_in_data == {$past(is_opener), $past(pwdata_i[7:0])})
		##1 (tx_push && tx_in_data == {1'b0, $past(pwdata_i[15:8], 2)})
		##1 (tx_push && tx_in_data == {1'b0, $past(pwdata_i[23:16], 3)})
		##1 (tx_push && tx_in_data == {1'b0, $past(pwdata_i[31:24], 4)});
	endproperty
	a_word_order: assert property (p_word_order) else $error("word byte order"); // see R16, R18

	property p_byte_push;
		@(posedge clock_i) disable iff (reset_i)
		(acc && pwrite_i && is_data && !is_word && tx_enough) |=>
		tx_push && tx_in_data == {$past(is_opener), $past(pwdata_i[7:0])};
	endproperty
	a_byte_push: assert property (p_byte_push) else $error("byte push wrong"); // see R13, R17

	property p_flush;
		@(posedge clock_i) disable iff (reset_i)
		s_flush_req |=> s.flush ##[1:FL_LIM] !s.flush;
	endproperty
	a_flush: assert property (p_flush) else $error("flush not bounded"); // see R21

	property p_keep;
		@(posedge clock_i) disable iff (reset_i)
		(acc && pwrite_i && paddr_i == OFS_STATUS && !pwdata_i[ST_STICKY_LO] && s.sticky[0])
		|=> s.sticky[0];
	endproperty
	a_keep: assert property (p_keep) else $error("sticky lost"); // see R22
endmodule

// [rtl/smc_pkg.sv]
// Constants and types for the controller message channel register port.
// Assumes a 12-bit byte address within the 4 KB channel window.
package smc_pkg;

	localparam int ADDR_W = 12;

	localparam logic [11:0] OFS_CONTROL      = 12'h000;
	localparam logic [11:0] OFS_STATUS       = 12'h004;
	localparam logic [11:0] OFS_INT_MASK     = 12'h008;
	localparam logic [11:0] OFS_BYTE_PAYLOAD = 12'h010;
	localparam logic [11:0] OFS_WORD_PAYLOAD = 12'h014;
	localparam logic [11:0] OFS_BYTE_OPENER  = 12'h018;
	localparam logic [11:0] OFS_WORD_OPENER  = 12'h01C;

	localparam int CTL_PURGE_REQ  = 0;
	localparam int CTL_PURGE_BUSY = 1;
	localparam int CTL_TX_WIDTH   = 2;
	localparam int CTL_RX_WIDTH   = 3;
	localparam int CTL_ENABLE     = 4;
	localparam int CTL_LOOPBACK   = 5;

	localparam int ST_TX_ROOM   = 0;
	localparam int ST_RX_UNIT   = 1;
	localparam int ST_STICKY_LO = 2;
	localparam int ST_STICKY_HI = 6;
	localparam int ST_CMD_HEAD  = 7;

	localparam logic       RST_LOOPBACK = 1'b1;
	localparam logic       RST_ENABLE   = 1'b0;
	localparam logic [7:0] RST_MASK     = 8'h00;

	localparam int       FIFO_DEPTH   = 4;
	localparam int       FIFO_WIDTH   = 9;
	localparam int       MARKER_BIT   = 8;
	localparam logic [2:0] WORD_BYTES   = 3'h4;
	localparam logic [2:0] FLUSH_CYCLES = 3'h4;

	typedef enum logic [1:0] {
		SMC_IDLE = 2'b00,
		SMC_MOVE = 2'b01,
		SMC_DONE = 2'b11
	} smc_state_t;

endpackage

// [test/smc_far_model.sv]
// Far-side controller model: takes transmit bytes, offers queued receive bytes.
// Assumes the bench sets stall/slow and calls offer() hierarchically.
`timescale 1ns/1ns
module smc_far_model (
	input  wire logic       clock_i,
	input  wire logic [7:0] tx_byte_i,
	input  wire logic       tx_marker_i,
	input  wire logic       tx_valid_i,
	output logic            tx_ready_o,
	output logic [7:0]      rx_byte_o,
	output logic            rx_marker_o,
	output logic            rx_valid_o,
	input  wire logic       rx_ready_i
);
	logic [8:0] got[$];
	logic [8:0] pend[$];
	logic       stall = 1'b1;
	logic       slow  = 1'b0;
	logic       tick  = 1'b0;

	initial begin
		tx_ready_o = 1'b0;
		rx_valid_o = 1'b0;
		{rx_marker_o, rx_byte_o} = 9'h0A5;
	end

	task automatic offer(input logic [8:0] b);
		pend.push_back(b);
	endtask

	always @(posedge clock_i) begin
		if (tx_valid_i && tx_ready_o)
			got.push_back({tx_marker_i, tx_byte_i});
		if (rx_valid_o && rx_ready_i)
			void'(pend.pop_front());
	end

	// Idle data shows the inverse so a stale byte never passes for a fresh one
	always @(negedge clock_i) begin
		tick <= !tick;
		tx_ready_o <= !stall && (!slow || tick);
		if (pend.size() > 0) begin
			rx_valid_o <= 1'b1;
			{rx_marker_o, rx_byte_o} <= pend[0];
		end else begin
			rx_valid_o <= 1'b0;
			{rx_marker_o, rx_byte_o} <= ~{rx_marker_o, rx_byte_o};
		end
	end
endmodule

// [test/sysctrl_message_fifo_port_tb.sv]
// Self-checking bench for the channel register port, far-side model attached.
// Assumes the APB timing and status layout of smc_pkg.
`timescale 1ns/1ns
module sysctrl_message_fifo_port_tb;
	import smc_pkg::*;
	logic        clock_i = 1'b0, reset_i = 1'b1;
	logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd, w;
	logic        pready_o, tx_marker_o, tx_valid_o, tx_ready_i, rx_marker_i, rx_valid_i;
	logic [7:0]  tx_byte_o, rx_byte_i, stk = 8'h00;
	logic        rx_ready_o, purge_in_progress_o, channel_irq_o;
	logic        sysbus_busy_i = 1'b0, sysbus_transfer_complete_i = 1'b0;
	logic        remote_purge_i = 1'b0, rxw = 1'b0, txw = 1'b0;
	logic [8:0]  txe[$], rxm[$];
	int          miscompares = 0, compares = 0, tx_occ = 0;
	int          seed = 32'h2ac87ca2;

	always #4 clock_i = ~clock_i;

	smc_port u_smc_port (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .tx_byte_o(tx_byte_o),
		.tx_marker_o(tx_marker_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
		.rx_byte_i(rx_byte_i), .rx_marker_i(rx_marker_i), .rx_valid_i(rx_valid_i),
		.rx_ready_o(rx_ready_o), .sysbus_busy_i(sysbus_busy_i),
		.sysbus_transfer_complete_i(sysbus_transfer_complete_i),
		.remote_purge_i(remote_purge_i), .purge_in_progress_o(purge_in_progress_o),
		.channel_irq_o(channel_irq_o));

	smc_far_model u_smc_far_model (.clock_i(clock_i), .tx_byte_i(tx_byte_o),
		.tx_marker_i(tx_marker_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
		.rx_byte_o(rx_byte_i), .rx_marker_o(rx_marker_i), .rx_valid_o(rx_valid_i),
		.rx_ready_i(rx_ready_o));

	task automatic results();
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(negedge clock_i);
		psel_i = 1'b1;
		pwrite_i = wr;
		paddr_i = a;
		pwdata_i = d;
		@(negedge clock_i);
		penable_i = 1'b1;
		@(posedge clock_i);
		while (pready_o !== 1'b1) begin
			n++;
			if (n > 20) begin
				miscompares++;
				results();
			end
			@(posedge clock_i);
		end
		rd = prdata_o;
		@(negedge clock_i);
		psel_i = 1'b0;
		penable_i = 1'b0;
	endtask

	function automatic logic [7:0] exp_st();
		exp_st = stk;
		exp_st[7] = rxm.size() > 0 && rxm[0][8];
		exp_st[1] = rxm.size() >= (rxw ? 4 : 1);
		exp_st[0] = (4 - tx_occ) >= (txw ? 4 : 1);
	endfunction

	task automatic st();
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("status", rd, {24'h0, exp_st()});
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = a[2] ? 4 : 1;
		bus(1'b1, a, d);
		txw = a[2];
		if (4 - tx_occ < n)
			stk[2] = 1'b1;
		else begin
			for (int i = 0; i < n; i++)
				txe.push_back({(i == 0) && a[3], d[8*i +: 8]});
			tx_occ += n;
		end
	endtask

	task automatic rdf(input logic [11:0] a);
		logic [31:0] e;
		logic [8:0]  b;
		int          n;
		n = a[2] ? 4 : 1;
		e = 32'h0;
		bus(1'b0, a, 32'h0);
		rxw = a[2];
		if (rxm.size() < n)
			stk[3] = 1'b1;
		else
			for (int i = 0; i < n; i++) begin
				b = rxm.pop_front();
				e[8*i +: 8] = b[7:0];
			end
		chk("rx_data", rd, e);
	endtask

	task automatic drain();
		int n;
		n = 0;
		u_smc_far_model.stall = 1'b0;
		while (u_smc_far_model.got.size() < txe.size()) begin
			@(posedge clock_i);
			n++;
			if (n > 200) begin
				miscompares++;
				results();
			end
		end
		repeat (4) @(negedge clock_i);
		u_smc_far_model.stall = 1'b1;
		chk("tx_count", u_smc_far_model.got.size(), txe.size());
		foreach (txe[i]) chk("tx_byte", u_smc_far_model.got[i], txe[i]);
		u_smc_far_model.got.delete();
		txe.delete();
		tx_occ = 0;
	endtask

	task automatic give(input logic m);
		logic [31:0] r;
		int          n;
		r = $random(seed);
		n = 0;
		u_smc_far_model.offer({m, r[7:0]});
		rxm.push_back({m, r[7:0]});
		while (u_smc_far_model.pend.size() > 0) begin
			@(negedge clock_i);
			n++;
			if (n > 50) begin
				miscompares++;
				results();
			end
		end
		repeat (3) @(negedge clock_i);
	endtask

	task automatic pulse(input int k);
		@(negedge clock_i);
		if (k == 0)
			remote_purge_i = 1'b1;
		else
			sysbus_transfer_complete_i = 1'b1;
		@(negedge clock_i);
		remote_purge_i = 1'b0;
		sysbus_transfer_complete_i = 1'b0;
	endtask

	initial begin
		repeat (12) @(posedge clock_i);
		@(negedge clock_i);
		reset_i = 1'b0;
		chk("idle_outs", {channel_irq_o, purge_in_progress_o, tx_valid_o, rx_ready_o}, 0);
		st();
		bus(1'b0, OFS_INT_MASK, 32'h0);
		chk("mask_reset", rd, 32'h0);
		bus(1'b0, OFS_CONTROL, 32'h0);
		chk("control_reset", rd, 32'h20);
		bus(1'b1, OFS_CONTROL, 32'h10);
		w = $random(seed);
		wr(OFS_WORD_OPENER, w);
		wr(OFS_BYTE_PAYLOAD, w ^ 32'h5A);
		st();
		drain();
		wr(OFS_BYTE_OPENER, $random(seed));
		wr(OFS_BYTE_PAYLOAD, $random(seed));
		wr(OFS_BYTE_PAYLOAD, $random(seed));
		wr(OFS_WORD_PAYLOAD, $random(seed));
		st();
		u_smc_far_model.slow = 1'b1;
		drain();
		wr(OFS_WORD_PAYLOAD, $random(seed));
		drain();
		u_smc_far_model.slow = 1'b0;
		bus(1'b1, OFS_STATUS, 32'h83);
		st();
		bus(1'b1, OFS_STATUS, 32'h04);
		stk[2] = 1'b0;
		st();
		give(1'b1);
		give(1'b0);
		give(1'b0);
		st();
		rdf(OFS_WORD_PAYLOAD);
		st();
		give(1'b0);
		st();
		rdf(OFS_WORD_OPENER);
		bus(1'b1, OFS_STATUS, 32'h08);
		stk[3] = 1'b0;
		rdf(OFS_BYTE_OPENER);
		st();
		pulse(0);
		stk[5] = 1'b1;
		pulse(1);
		stk[4] = 1'b1;
		sysbus_busy_i = 1'b1;
		wr(OFS_BYTE_PAYLOAD, $random(seed));
		drain();
		st();
		wr(OFS_BYTE_OPENER, $random(seed));
		drain();
		sysbus_busy_i = 1'b0;
		stk[6] = 1'b1;
		st();
		bus(1'b1, OFS_INT_MASK, 32'h20);
		bus(1'b0, OFS_INT_MASK, 32'h0);
		chk("mask_rb", rd, 32'h20);
		chk("irq_on", channel_irq_o, 1'b1);
		bus(1'b1, OFS_STATUS, 32'h7C);
		stk = 8'h00;
		st();
		chk("irq_off", channel_irq_o, 1'b0);
		bus(1'b1, OFS_INT_MASK, 32'h01);
		@(negedge clock_i);
		chk("irq_room", channel_irq_o, 1'b1);
		wr(OFS_WORD_PAYLOAD, $random(seed));
		// Keep the word transmit width while starting the flush
		bus(1'b1, OFS_CONTROL, 32'h15);
		chk("purge_busy", purge_in_progress_o, 1'b1);
		repeat (6) @(negedge clock_i);
		chk("purge_done", purge_in_progress_o, 1'b0);
		txe.delete();
		tx_occ = 0;
		bus(1'b0, OFS_CONTROL, 32'h0);
		chk("control_after", rd, 32'h14);
		st();
		drain();
		// Mid-run reset must bring back loopback and byte widths
		reset_i = 1'b1;
		repeat (2) @(negedge clock_i);
		reset_i = 1'b0;
		txw = 1'b0;
		rxw = 1'b0;
		chk("idle_outs_rst2", {channel_irq_o, purge_in_progress_o, tx_valid_o, rx_ready_o}, 0);
		st();
		bus(1'b0, OFS_CONTROL, 32'h0);
		chk("control_rst2", rd, 32'h20);
		results();
	end
endmodule
